// ===== hdl/supervisor_pkg.sv
// Purpose: Supervisor types and constants.
// Assumes: 200 MHz clock; filtered synchronous comparators.
// Notes: Timing counts default the module parameters.
package supervisor_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned SC_FILTER_US = 2000;
   localparam int unsigned RESET_DELAY_LONG_US = 10000;
   localparam int unsigned AUX_BLANK_US = 100;
   localparam int unsigned COOLDOWN_US = 1000;
   localparam int unsigned SC_FILTER_CYC = SC_FILTER_US * CLK_MHZ;
   localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_LONG_US * CLK_MHZ;
   localparam int unsigned AUX_BLANK_CYC = AUX_BLANK_US * CLK_MHZ;
   localparam int unsigned COOLDOWN_CYC = COOLDOWN_US * CLK_MHZ;
   localparam int unsigned COOLDOWN_STRETCH = 64;
   localparam logic [4:0] TSD_COUNT_LIMIT = 5'h10;
   localparam int unsigned CNT_W = 32;
   localparam logic [1:0] TRX_FAULT_OVERTEMP = 2'h1;
   localparam logic [1:0] TRX_FAULT_NONE = 2'h0;
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned WAKE_W = 3;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      mode_init,
      mode_normal,
      mode_stop,
      mode_sleep,
      mode_restart,
      mode_failsafe
   } mode_e;

   typedef struct packed {
      logic supply_uv, supply_ov, main_below_prewarn, main_below_reset, main_above_selected_rise;
      logic main_above_highest_rise, main_ov, main_load_peak, aux_uv, trx_supply_uv, aux_hot, trx_hot;
      logic main_tpw, chip_hot;
   } cmp_s;

   typedef struct packed {
      logic supply_undervoltage_flag, supply_overvoltage_flag, main_rail_prewarn_flag;
      logic main_rail_undervoltage_flag, main_rail_overvoltage_flag, main_rail_short_flag, fault_latched_flag;
      logic aux_rail_undervoltage_flag, transceiver_supply_undervoltage_flag, block_thermal_shutdown_flag;
      logic aux_rail_overtemp_flag, thermal_prewarn_flag, chip_thermal_shutdown_flag, extended_cooldown_active_flag;
   } flags_s;

   typedef struct packed {
      logic valid;
      mode_e mode;
   } mode_req_s;

endpackage : supervisor_pkg

// ===== hdl/supply_thermal_supervisor.sv
// Purpose: Supply, rail and thermal supervision.
// Assumes: Mode controller applies mode_request.
// Notes: A flag set wins over a same-cycle clear; hardware clears of control bits beat writes.
`timescale 1ns/1ps

module supply_thermal_supervisor #(
   parameter int unsigned SC_CYC = supervisor_pkg::SC_FILTER_CYC,
   parameter int unsigned RST_DELAY_CYC = supervisor_pkg::RESET_DELAY_CYC,
   parameter int unsigned BLANK_CYC = supervisor_pkg::AUX_BLANK_CYC,
   parameter int unsigned COOL_CYC = supervisor_pkg::COOLDOWN_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire supervisor_pkg::cmp_s cmp,
   input wire supervisor_pkg::mode_e mode,
   input wire logic charge_pump_enable,
   input wire logic main_rail_enable,
   input wire logic transceiver_enable,
   input wire logic reset_release_hysteresis_select,
   input wire logic restart_vs_failsafe_config,
   input wire logic extended_cooldown_enable,
   input wire logic overvoltage_reset_enable_wr,
   input wire logic overvoltage_reset_enable_wdata,
   input wire logic aux_rail_on_wr,
   input wire logic aux_rail_on_wdata,
   input wire supervisor_pkg::flags_s flag_clear,
   input wire logic transceiver_fault_clear,
   input wire logic fail_output_clear,
   input wire logic bus_wake,
   input wire logic wake_input,
   input wire logic gpio_wake,
   output supervisor_pkg::flags_s flags,
   output logic overvoltage_reset_enable,
   output logic aux_rail_on_field,
   output logic [1:0] transceiver_fault_field,
   output logic transmitter_enable,
   output logic main_rail_on,
   output logic reset_output_n,
   output logic fail_output,
   output supervisor_pkg::mode_req_s mode_request
);
   import supervisor_pkg::*;
   typedef enum logic [3:0] {sv_run, sv_uv_hold, sv_uv_delay, sv_ov_restart, sv_fs_ov, sv_fs_short,
      sv_tsd_hot, sv_tsd_cool, sv_tsd_restart} sv_state_e;
   sv_state_e state_q;
   flags_s flags_q;
   logic [WAKE_W-1:0] wake_s1_q, wake_s2_q, wake_s3_q;
   logic [CNT_W-1:0] delay_q, sc_cnt_q, blank_q, cool_limit;
   logic [4:0] tsd_cnt_q;
   logic chip_hot_q, main_ov_q, ext_en_q, aux_on_prev_q, short_off_q;
   logic ovr_en_q, aux_on_q, fail_q, reset_output_n_q;
   logic [1:0] trx_fault_q;
   mode_req_s req_q;
   logic wake_any, active_mode, eval_uv, eval_ov, main_on, sc_active;
   logic short_evt, chip_evt, ov_evt, uv_trip, uv_release, blanking;
   ////////////////////////////////////////////////////////////////////////////
   // Three-flop wake sync; stages two and three agree
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_s1_q <= '0;
         wake_s2_q <= '0;
         wake_s3_q <= '0;
      end else begin
         wake_s1_q <= {bus_wake, wake_input, gpio_wake};
         wake_s2_q <= wake_s1_q;
         wake_s3_q <= wake_s2_q;
      end
   end
   assign wake_any = |(wake_s2_q & wake_s3_q);
   ////////////////////////////////////////////////////////////////////////////
   assign active_mode = (mode == mode_init) || (mode == mode_restart) || (mode == mode_normal);
   assign eval_uv = active_mode || (mode == mode_stop && (cmp.main_load_peak || cmp.main_below_prewarn));
   assign eval_ov = eval_uv || charge_pump_enable;
   assign main_on = main_rail_enable && !short_off_q && mode != mode_sleep;
   assign sc_active = !cmp.supply_uv;
   assign short_evt = main_on && sc_active && cmp.main_below_reset && sc_cnt_q >= CNT_W'(SC_CYC);
   assign chip_evt = cmp.chip_hot && !chip_hot_q;
   assign ov_evt = main_on && cmp.main_ov && !main_ov_q;
   assign uv_trip = main_on && cmp.main_below_reset;
   assign uv_release = reset_release_hysteresis_select ? cmp.main_above_highest_rise
                                                       : cmp.main_above_selected_rise;
   assign blanking = blank_q != '0;
   // Stretched wait only while the active flag stands
   assign cool_limit = flags_q.extended_cooldown_active_flag ? CNT_W'(COOL_CYC * COOLDOWN_STRETCH)
                                                             : CNT_W'(COOL_CYC);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chip_hot_q <= 1'b0;
         main_ov_q <= 1'b0;
         ext_en_q <= 1'b0;
         aux_on_prev_q <= 1'b0;
      end else begin
         chip_hot_q <= cmp.chip_hot;
         main_ov_q <= cmp.main_ov;
         ext_en_q <= extended_cooldown_enable;
         aux_on_prev_q <= aux_on_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Short filter: startup and later drop alike
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sc_cnt_q <= '0;
      end else if (!main_on || !sc_active || !cmp.main_below_reset) begin
         sc_cnt_q <= '0;
      end else if (sc_cnt_q < CNT_W'(SC_CYC)) begin
         sc_cnt_q <= sc_cnt_q + CNT_W'(1);
      end
   end
   // Blanking restarts on power-up and on every aux switch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blank_q <= CNT_W'(BLANK_CYC);
      end else if (aux_on_q != aux_on_prev_q) begin
         blank_q <= CNT_W'(BLANK_CYC);
      end else if (blanking) begin
         blank_q <= blank_q - CNT_W'(1);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Software-owned control bits that hardware may clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ovr_en_q <= 1'b0;
         aux_on_q <= 1'b0;
      end else begin
         if (state_q == sv_ov_restart && delay_q == '0) begin
            ovr_en_q <= 1'b0;
         end else if (overvoltage_reset_enable_wr) begin
            ovr_en_q <= overvoltage_reset_enable_wdata;
         end
         // Overtemperature beats a write only while the rail is on; a write while off and hot still turns it on
         if (aux_on_q && cmp.aux_hot) begin
            aux_on_q <= 1'b0;
         end else if (aux_rail_on_wr) begin
            aux_on_q <= aux_rail_on_wdata;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trx_fault_q <= TRX_FAULT_NONE;
      end else if (transceiver_enable && cmp.trx_hot) begin
         trx_fault_q <= TRX_FAULT_OVERTEMP;
      end else if (transceiver_fault_clear) begin
         trx_fault_q <= TRX_FAULT_NONE;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Diagnostic flags; set terms listed first win over clears
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags_q <= '0;
      end else begin
         flags_q.supply_undervoltage_flag <= (eval_uv && cmp.supply_uv) ||
            (flags_q.supply_undervoltage_flag && !(flag_clear.supply_undervoltage_flag && !cmp.supply_uv));
         flags_q.supply_overvoltage_flag <= (eval_ov && cmp.supply_ov) ||
            (flags_q.supply_overvoltage_flag && !(flag_clear.supply_overvoltage_flag && !cmp.supply_ov));
         flags_q.main_rail_prewarn_flag <= (main_on && cmp.main_below_prewarn) ||
            (flags_q.main_rail_prewarn_flag && !flag_clear.main_rail_prewarn_flag);
         flags_q.main_rail_undervoltage_flag <= (state_q == sv_uv_delay && delay_q == '0) ||
            (flags_q.main_rail_undervoltage_flag && !flag_clear.main_rail_undervoltage_flag);
         flags_q.main_rail_overvoltage_flag <= (main_on && cmp.main_ov) ||
            (flags_q.main_rail_overvoltage_flag && !flag_clear.main_rail_overvoltage_flag);
         flags_q.main_rail_short_flag <= short_evt ||
            (flags_q.main_rail_short_flag && !flag_clear.main_rail_short_flag);
         flags_q.fault_latched_flag <= short_evt ||
            (flags_q.fault_latched_flag && !flag_clear.fault_latched_flag);
         flags_q.aux_rail_undervoltage_flag <= (aux_on_q && !blanking && cmp.aux_uv) ||
            (flags_q.aux_rail_undervoltage_flag && !flag_clear.aux_rail_undervoltage_flag);
         flags_q.transceiver_supply_undervoltage_flag <= (transceiver_enable && cmp.trx_supply_uv) ||
            (flags_q.transceiver_supply_undervoltage_flag &&
             !flag_clear.transceiver_supply_undervoltage_flag);
         flags_q.block_thermal_shutdown_flag <= (aux_on_q && cmp.aux_hot) ||
            (transceiver_enable && cmp.trx_hot) ||
            (flags_q.block_thermal_shutdown_flag &&
             !(flag_clear.block_thermal_shutdown_flag && !cmp.aux_hot && !cmp.trx_hot));
         flags_q.aux_rail_overtemp_flag <= (aux_on_q && cmp.aux_hot) ||
            (flags_q.aux_rail_overtemp_flag && !flag_clear.aux_rail_overtemp_flag);
         flags_q.thermal_prewarn_flag <= cmp.main_tpw ||
            (flags_q.thermal_prewarn_flag && !(flag_clear.thermal_prewarn_flag && !cmp.main_tpw));
         flags_q.chip_thermal_shutdown_flag <= chip_evt ||
            (flags_q.chip_thermal_shutdown_flag &&
             !(flag_clear.chip_thermal_shutdown_flag && mode == mode_normal && !cmp.chip_hot));
         flags_q.extended_cooldown_active_flag <= (chip_evt && extended_cooldown_enable &&
            tsd_cnt_q == TSD_COUNT_LIMIT - 5'h1) ||
            (flags_q.extended_cooldown_active_flag && !flag_clear.extended_cooldown_active_flag);
      end
   end
   // Shutdown counter; an event in a flag-clearing cycle still counts, one in an extension-disabling cycle is lost
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tsd_cnt_q <= '0;
      end else if ((flags_q.chip_thermal_shutdown_flag && flag_clear.chip_thermal_shutdown_flag && !chip_evt &&
                    mode == mode_normal && !cmp.chip_hot) || (ext_en_q && !extended_cooldown_enable)) begin
         tsd_cnt_q <= '0;
      end else if (chip_evt && tsd_cnt_q < TSD_COUNT_LIMIT) begin
         tsd_cnt_q <= tsd_cnt_q + 5'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Recovery sequencer; chip shutdown, short, overvoltage, undervoltage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= sv_run;
         delay_q <= '0;
         req_q <= '{valid: 1'b0, mode: mode_init};
      end else begin
         req_q.valid <= 1'b0;
         if (delay_q != '0) begin
            delay_q <= delay_q - CNT_W'(1);
         end
         if (chip_evt && state_q != sv_tsd_hot) begin
            state_q <= sv_tsd_hot;
            req_q <= '{valid: 1'b1, mode: mode_failsafe};
         end else begin
            unique case (state_q)
               sv_run, sv_uv_hold, sv_uv_delay: begin
                  if (short_evt) begin
                     state_q <= sv_fs_short;
                     req_q <= '{valid: 1'b1, mode: mode_failsafe};
                  end else if (ov_evt && ovr_en_q && restart_vs_failsafe_config) begin
                     state_q <= sv_ov_restart;
                     delay_q <= CNT_W'(RST_DELAY_CYC);
                     req_q <= '{valid: 1'b1, mode: mode_restart};
                  end else if (ov_evt && ovr_en_q) begin
                     state_q <= sv_fs_ov;
                     req_q <= '{valid: 1'b1, mode: mode_failsafe};
                  end else if (state_q == sv_run && uv_trip) begin
                     state_q <= sv_uv_hold;
                     req_q <= '{valid: 1'b1, mode: mode_restart};
                  end else if (state_q == sv_uv_hold && uv_release) begin
                     state_q <= sv_uv_delay;
                     delay_q <= CNT_W'(RST_DELAY_CYC);
                  end else if (state_q == sv_uv_delay && !uv_release) begin
                     state_q <= sv_uv_hold;
                  end else if (state_q == sv_uv_delay && delay_q == '0) begin
                     state_q <= sv_run;
                     req_q <= '{valid: 1'b1, mode: mode_normal};
                  end
               end
               sv_ov_restart: begin
                  // Normal resumes even if the overvoltage persists
                  if (delay_q == '0) begin
                     state_q <= sv_run;
                     req_q <= '{valid: 1'b1, mode: mode_normal};
                  end
               end
               sv_fs_ov, sv_fs_short: begin
                  if (wake_any) begin
                     state_q <= sv_tsd_restart;
                     delay_q <= CNT_W'(RST_DELAY_CYC);
                     req_q <= '{valid: 1'b1, mode: mode_restart};
                  end
               end
               sv_tsd_hot: begin
                  if (!cmp.chip_hot) begin
                     state_q <= sv_tsd_cool;
                     delay_q <= cool_limit;
                  end
               end
               sv_tsd_cool: begin
                  if (delay_q == '0) begin
                     state_q <= sv_tsd_restart;
                     delay_q <= CNT_W'(RST_DELAY_CYC);
                     req_q <= '{valid: 1'b1, mode: mode_restart};
                  end
               end
               sv_tsd_restart: begin
                  if (delay_q == '0) begin
                     state_q <= sv_run;
                     req_q <= '{valid: 1'b1, mode: mode_normal};
                  end
               end
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Short latch drops the rail until a wake
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         short_off_q <= 1'b0;
      end else if (short_evt) begin
         short_off_q <= 1'b1;
      end else if ((state_q == sv_fs_short) && wake_any) begin
         short_off_q <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fail_q <= 1'b0;
         reset_output_n_q <= 1'b0;
      end else begin
         if (short_evt || (ov_evt && ovr_en_q && state_q != sv_tsd_hot)) begin
            fail_q <= 1'b1;
         end else if (fail_output_clear) begin
            fail_q <= 1'b0;
         end
         reset_output_n_q <= (state_q == sv_run) && !uv_trip && !short_evt && !chip_evt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   assign flags = flags_q;
   assign overvoltage_reset_enable = ovr_en_q;
   assign aux_rail_on_field = aux_on_q;
   assign transceiver_fault_field = trx_fault_q;
   assign transmitter_enable = transceiver_enable && !cmp.trx_hot;
   assign main_rail_on = main_on;
   assign reset_output_n = reset_output_n_q;
   assign fail_output = fail_q;
   assign mode_request = req_q;
endmodule : supply_thermal_supervisor

// ===== bench/supervisor_chk.sv
// Purpose: Supervisor port assertions.
// Assumes: One clock.
// Notes: Bound below.
`timescale 1ns/1ps
module supervisor_chk
   import supervisor_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire supervisor_pkg::cmp_s cmp,
   input wire supervisor_pkg::mode_e mode,
   input wire logic transceiver_enable,
   input wire logic restart_vs_failsafe_config,
   input wire supervisor_pkg::flags_s flags,
   input wire logic overvoltage_reset_enable,
   input wire logic [1:0] transceiver_fault_field,
   input wire logic fail_output,
   input wire supervisor_pkg::mode_req_s mode_request
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   property p_uv_set; cmp.supply_uv && mode == mode_normal |=> flags.supply_undervoltage_flag; endproperty
   a_uv_set: assert property (p_uv_set) else $error("supply uv flag missing");
   property p_uv_hold; flags.supply_undervoltage_flag && cmp.supply_uv |=> flags.supply_undervoltage_flag; endproperty
   a_uv_hold: assert property (p_uv_hold) else $error("supply uv flag lost");
   property p_trx; transceiver_enable && cmp.trx_hot |=> transceiver_fault_field == TRX_FAULT_OVERTEMP; endproperty
   a_trx: assert property (p_trx) else $error("transceiver fault code wrong");
   property p_sleep; mode == mode_sleep && !flags.main_rail_prewarn_flag |=> !flags.main_rail_prewarn_flag; endproperty
   a_sleep: assert property (p_sleep) else $error("prewarn set in sleep");
   property p_ov_rst; $rose(cmp.main_ov) && overvoltage_reset_enable && restart_vs_failsafe_config && !cmp.chip_hot
      |=> mode_request.valid && mode_request.mode == mode_restart && fail_output; endproperty
   a_ov_rst: assert property (p_ov_rst) else $error("overvoltage restart missing");
   property p_ov_fs; $rose(cmp.main_ov) && overvoltage_reset_enable && !restart_vs_failsafe_config && !cmp.chip_hot
      |=> mode_request.valid && mode_request.mode == mode_failsafe && fail_output; endproperty
   a_ov_fs: assert property (p_ov_fs) else $error("overvoltage fail-safe missing");
   property p_tsd_set; $rose(cmp.chip_hot) |=> mode_request.valid && mode_request.mode == mode_failsafe
      && flags.chip_thermal_shutdown_flag; endproperty
   a_tsd_set: assert property (p_tsd_set) else $error("shutdown response missing");
   // Clear only in Normal once cooled
   property p_tsd_hold; flags.chip_thermal_shutdown_flag && (mode != mode_normal || cmp.chip_hot)
      |=> flags.chip_thermal_shutdown_flag; endproperty
   a_tsd_hold: assert property (p_tsd_hold) else $error("chip shutdown flag lost");
endmodule : supervisor_chk

bind supply_thermal_supervisor supervisor_chk chk (.clk, .sys_rst, .cmp, .mode, .transceiver_enable,
   .restart_vs_failsafe_config, .flags, .overvoltage_reset_enable, .transceiver_fault_field, .fail_output,
   .mode_request);

// ===== bench/host_model.sv
// Purpose: Host register writes.
// Assumes: One-clock strobes.
// Notes: Calls may run back to back.
`timescale 1ns/1ps
module host_model
   import supervisor_pkg::*;
(
   input wire logic clk,
   output supervisor_pkg::flags_s flag_clear,
   output logic ov_wr,
   output logic ov_wdata
);
   initial begin
      flag_clear = '0;
      ov_wr = 1'b0;
      ov_wdata = 1'b0;
   end
   task automatic clear(input flags_s m);
      @(posedge clk) flag_clear <= m;
      @(posedge clk) flag_clear <= '0;
   endtask : clear
   task automatic write_ov(input logic v);
      @(posedge clk) begin
         ov_wr <= 1'b1;
         ov_wdata <= v;
      end
      @(posedge clk) ov_wr <= 1'b0;
   endtask : write_ov
   // Avoids noise restarts in Stop
   task automatic prep_stop();
      write_ov(1'b0);
   endtask : prep_stop
endmodule : host_model

// ===== bench/supply_thermal_supervisor_tb.sv
// Purpose: Supervisor bench.
// Assumes: Mode follows requests.
// Notes: Short timing counts.
`timescale 1ns/1ps
module supply_thermal_supervisor_tb;
   import supervisor_pkg::*;
   localparam int RST_N = 30;
   localparam int COOL_N = 16;
   logic clk, sys_rst, cp_en, rail_en, trx_en, hys, cfg, ext_en, aux_wr, aux_wd, trx_clr, fo_clr;
   logic bus_wake, wake_input, gpio_wake, ov_en, aux_on, tx_en, rail_on, rst_n, fo, ov_wr, ov_wd;
   logic [1:0] trx_fault;
   cmp_s cmp;
   mode_e mode;
   flags_s flags, flag_clear, clr;
   mode_req_s req;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   host_model host (.clk(clk), .flag_clear(flag_clear), .ov_wr(ov_wr), .ov_wdata(ov_wd));
   supply_thermal_supervisor #(.SC_CYC(20), .RST_DELAY_CYC(RST_N), .BLANK_CYC(10), .COOL_CYC(COOL_N)) dut (
      .clk(clk), .sys_rst(sys_rst), .cmp(cmp), .mode(mode), .charge_pump_enable(cp_en), .main_rail_enable(rail_en),
      .transceiver_enable(trx_en), .reset_release_hysteresis_select(hys), .restart_vs_failsafe_config(cfg),
      .extended_cooldown_enable(ext_en), .overvoltage_reset_enable_wr(ov_wr), .overvoltage_reset_enable_wdata(ov_wd),
      .aux_rail_on_wr(aux_wr), .aux_rail_on_wdata(aux_wd), .flag_clear(flag_clear), .transceiver_fault_clear(trx_clr),
      .fail_output_clear(fo_clr), .bus_wake(bus_wake), .wake_input(wake_input), .gpio_wake(gpio_wake),
      .flags(flags), .overvoltage_reset_enable(ov_en), .aux_rail_on_field(aux_on), .transceiver_fault_field(trx_fault),
      .transmitter_enable(tx_en), .main_rail_on(rail_on), .reset_output_n(rst_n), .fail_output(fo),
      .mode_request(req));
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task automatic check(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // n counts edges
   task automatic wait_req(input mode_e m, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(req.valid === 1'b1 && req.mode === m) && n < 3000);
      check("mode request", 1'b1, n < 3000);
   endtask : wait_req
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_supply_uv();
      clr = '0;
      clr.supply_undervoltage_flag = 1'b1;
      @(posedge clk) cmp.supply_uv <= 1'b1;
      tick(2);
      check("uv flag", 1'b1, flags.supply_undervoltage_flag);
      host.clear(clr);
      tick(1);
      check("uv flag held", 1'b1, flags.supply_undervoltage_flag);
      @(posedge clk) cmp.supply_uv <= 1'b0;
      host.clear(clr);
      tick(1);
      check("uv flag cleared", 1'b0, flags.supply_undervoltage_flag);
      host.prep_stop();
      @(posedge clk) begin
         mode <= mode_stop;
         cmp.supply_uv <= 1'b1;
      end
      tick(3);
      check("uv in stop", 1'b0, flags.supply_undervoltage_flag);
      @(posedge clk) cmp.main_load_peak <= 1'b1;
      tick(3);
      check("uv in stop at peak", 1'b1, flags.supply_undervoltage_flag);
      @(posedge clk) begin
         mode <= mode_normal;
         cmp.supply_uv <= 1'b0;
         cmp.main_load_peak <= 1'b0;
      end
      host.clear(clr);
   endtask : t_supply_uv
   task automatic t_prewarn();
      @(posedge clk) begin
         mode <= mode_sleep;
         cmp.main_below_prewarn <= 1'b1;
      end
      tick(3);
      check("prewarn in sleep", 1'b0, flags.main_rail_prewarn_flag);
      @(posedge clk) mode <= mode_normal;
      tick(3);
      check("prewarn", 1'b1, flags.main_rail_prewarn_flag);
      check("no reset on prewarn", 1'b1, rst_n);
      @(posedge clk) cmp.main_below_prewarn <= 1'b0;
   endtask : t_prewarn
   task automatic t_rail_uv();
      int n;
      @(posedge clk) begin
         hys <= 1'b1;
         cmp.main_below_reset <= 1'b1;
         cmp.main_above_selected_rise <= 1'b0;
         cmp.main_above_highest_rise <= 1'b0;
      end
      wait_req(mode_restart, n);
      check("reset low", 1'b0, rst_n);
      @(posedge clk) begin
         cmp.main_below_reset <= 1'b0;
         cmp.main_above_selected_rise <= 1'b1;
      end
      tick(50);
      check("reset held", 1'b0, rst_n);
      @(posedge clk) cmp.main_above_highest_rise <= 1'b1;
      wait_req(mode_normal, n);
      tick(2);
      check("reset released", 1'b1, rst_n);
      check("rail uv flag", 1'b1, flags.main_rail_undervoltage_flag);
   endtask : t_rail_uv
   task automatic t_ov();
      int n;
      host.write_ov(1'b1);
      @(posedge clk) begin
         cfg <= 1'b1;
         cmp.main_ov <= 1'b1;
      end
      wait_req(mode_restart, n);
      check("fail output", 1'b1, fo);
      check("ov flag", 1'b1, flags.main_rail_overvoltage_flag);
      wait_req(mode_normal, n);
      check("restart delay", 1'b1, n >= RST_N && n <= RST_N + 2);
      tick(1);
      check("ov enable cleared", 1'b0, ov_en);
      @(posedge clk) begin
         fo_clr <= 1'b1;
         cfg <= 1'b0;
         cmp.main_ov <= 1'b0;
      end
      @(posedge clk) fo_clr <= 1'b0;
      host.write_ov(1'b1);
      check("fail output cleared", 1'b0, fo);
      @(posedge clk) cmp.main_ov <= 1'b1;
      wait_req(mode_failsafe, n);
      check("fail output", 1'b1, fo);
      @(posedge clk) begin
         wake_input <= 1'b1;
         cmp.main_ov <= 1'b0;
      end
      wait_req(mode_restart, n);
      @(posedge clk) wake_input <= 1'b0;
      wait_req(mode_normal, n);
   endtask : t_ov
   task automatic t_tsd();
      int n, k, exp_n;
      clr = '0;
      clr.chip_thermal_shutdown_flag = 1'b1;
      @(posedge clk) ext_en <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk) cmp.chip_hot <= 1'b1;
         wait_req(mode_failsafe, k);
         host.clear(clr);
         tick(1);
         check("tsd flag held", 1'b1, flags.chip_thermal_shutdown_flag);
         check("extended active", i == 15, flags.extended_cooldown_active_flag);
         @(posedge clk) cmp.chip_hot <= 1'b0;
         wait_req(mode_restart, n);
         exp_n = (i == 15) ? COOL_N * 64 : COOL_N;
         check("cool-down", 1'b1, n >= exp_n && n <= exp_n + 3);
         wait_req(mode_normal, k);
      end
      clr.extended_cooldown_active_flag = 1'b1;
      host.clear(clr);
      tick(1);
      check("tsd flag cleared", 1'b0, flags.chip_thermal_shutdown_flag);
      check("extended cleared", 1'b0, flags.extended_cooldown_active_flag);
   endtask : t_tsd
   task automatic t_trx();
      @(posedge clk) begin
         trx_en <= 1'b1;
         cmp.trx_hot <= 1'b1;
      end
      tick(2);
      check("transmitter off", 1'b0, tx_en);
      check("trx fault", 1'b1, trx_fault === TRX_FAULT_OVERTEMP);
      check("block tsd flag", 1'b1, flags.block_thermal_shutdown_flag);
      @(posedge clk) cmp.trx_hot <= 1'b0;
      tick(2);
      check("transmitter back", 1'b1, tx_en);
      @(posedge clk) trx_clr <= 1'b1;
      @(posedge clk) trx_clr <= 1'b0;
      tick(1);
      check("trx fault cleared", 1'b1, trx_fault === TRX_FAULT_NONE);
   endtask : t_trx
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_errors++;
         close_out();
      end
   end
   always @(posedge clk) if (req.valid === 1'b1) mode <= req.mode;
   initial begin
      sys_rst = 1'b1;
      cmp = '0;
      cmp.main_above_selected_rise = 1'b1;
      cmp.main_above_highest_rise = 1'b1;
      mode = mode_normal;
      {cp_en, trx_en, hys, cfg, ext_en, aux_wr, aux_wd, trx_clr, fo_clr, bus_wake, wake_input, gpio_wake} = '0;
      rail_en = 1'b1;
      tick(8);
      sys_rst <= 1'b0;
      tick(4);
      check("reset after start", 1'b1, rst_n);
      t_supply_uv();
      t_prewarn();
      t_rail_uv();
      t_ov();
      t_tsd();
      t_trx();
      close_out();
   end
endmodule : supply_thermal_supervisor_tb
